//--- common/zc_pkg.sv
/*
 * Constants and carrier types for the zero-cross detector digital side.
 * Assumes a single 100 MHz clock and a byte-wide register port.
 */
`default_nettype none

package zc_pkg;

    localparam logic [1:0] OFF_PRIMARY_CONTROL = 2'h0;
    localparam logic [1:0] OFF_IRQ_CONTROL = 2'h2;
    localparam logic [1:0] OFF_STATUS = 2'h3;
    localparam logic [1:0] OFF_IRQ_MASK = 2'h1;

    localparam int BIT_ENABLE = 0;
    localparam int BIT_INVERT = 3;
    localparam int BIT_PIN_DRIVE = 6;
    localparam int BIT_STANDBY = 7;
    localparam int BIT_FLAG = 0;
    localparam int BIT_STATE = 4;

    localparam logic [7:0] RST_PRIMARY_CONTROL = 8'h00;
    localparam logic [1:0] RST_IRQ_EDGE = 2'h0;
    localparam logic RST_IRQ_MASK = 1'b1;

    localparam int SYNC_STAGES = 3;

    typedef enum logic [1:0]
    {
        EDGE_NONE = 2'h0,
        EDGE_RISING = 2'h1,
        EDGE_FALLING = 2'h2,
        EDGE_BOTH = 2'h3
    } irq_edge_e;

    typedef struct packed
    {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

endpackage : zc_pkg

`default_nettype wire

//--- dv/ac_front_model.sv
/*
 * Comparator front end model: turns a requested level into an async result.
 * Assumes the bench sets the requested level on clock edges.
 */
`timescale 1ns/1ps
`default_nettype none

module ac_front_model
(
    input wire logic level_i,
    output logic comp_o
);
    // Pad is analog with no pulls, so only the comparator drives it
    // Skew moves each result change 3 ns past the clock edge that set the level
    initial
    begin
        comp_o = 1'b0;
        forever @(level_i) comp_o <= #3 level_i;
    end
endmodule : ac_front_model

`default_nettype wire

//--- dv/tb_zero_cross_edge_detector.sv
/*
 * Self-checking bench for the zero-cross detector digital side.
 * Assumes the comparator front end model and a 100 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_zero_cross_edge_detector;
    logic clock_i = 0, rst_n_i = 0, lvl = 0, standby_i = 0, wr = 0, rd = 0;
    logic [1:0] addr = 0;
    logic [7:0] wd = 0;
    logic [7:0] rdata;
    logic comp, cdo, pout, poe_n, ev, irq;
    logic en = 0, inv = 0, pd = 0, flag = 0, mask = 1, keep = 0, out;
    logic [1:0] mode = 0;
    int failures = 0, checked = 0, cyc = 0;

    initial forever #5 clock_i = ~clock_i;

    ac_front_model fe (.level_i(lvl), .comp_o(comp));

    zero_cross_edge_detector uut (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .comp_raw_i(comp), .standby_i(standby_i), .reg_addr_i(addr),
        .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .cross_detect_output_o(cdo), .pin_out_o(pout), .pin_oe_n_o(poe_n),
        .event_level_o(ev), .irq_o(irq));

    task automatic wrap_up;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: reg %h exp %h", $time, got, exp);
        end
    endtask : check_reg

    task automatic check_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: pin %b exp %b", $time, got, exp);
        end
    endtask : check_bit

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        #1 check_reg(rdata, exp);
    endtask : rd_reg

    task automatic pins;
        out = en & (!standby_i | keep) & (lvl ^ inv);
        check_bit(cdo, out);
        check_bit(ev, out);
        check_bit(pout, out & pd);
        check_bit(poe_n, !(pd && en && (!standby_i || keep)));
        check_bit(irq, flag && mask && mode != 2'h0);
    endtask : pins

    // Settling time covers the three-stage synchroniser plus the edge stage
    task automatic set_lvl(input logic v);
        @(posedge clock_i);
        lvl <= v;
        repeat (8) @(posedge clock_i);
        if (en && (!standby_i || keep) && ((v ^ inv) ? mode[0] : mode[1]))
            flag = 1'b1;
        #1 pins();
        rd_reg(2'h3, {3'h0, out, 3'h0, flag});
    endtask : set_lvl

    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            failures++;
            wrap_up();
        end
    end

    initial
    begin
        void'($urandom(32'hBB28));
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd_reg(2'h0, 8'h00);
        rd_reg(2'h1, 8'h01);
        rd_reg(2'h2, 8'h00);
        rd_reg(2'h3, 8'h00);
        mode = 2'h3;
        wr_reg(2'h2, 8'h03);
        set_lvl(1'b1);
        set_lvl(1'b0);
        for (int i = 0; i < 8; i++)
        begin
            mode = 2'(i);
            inv = i[2];
            pd = 1'($urandom % 2);
            en = 1'b1;
            wr_reg(2'h0, {1'b0, pd, 2'h0, inv, 3'h1});
            wr_reg(2'h2, {6'h0, mode});
            // Output may be invalid during start-up, so flag is cleared
            repeat (8) @(posedge clock_i);
            wr_reg(2'h3, 8'h01);
            flag = 1'b0;
            set_lvl(1'b1);
            set_lvl(1'b0);
            wr_reg(2'h3, 8'h00);
            rd_reg(2'h3, {3'h0, inv, 3'h0, flag});
            mask = 1'b0;
            wr_reg(2'h1, 8'h00);
            #1 pins();
            mask = 1'b1;
            wr_reg(2'h1, 8'h01);
            #1 pins();
            wr_reg(2'h3, 8'h01);
            flag = 1'b0;
            #1 pins();
        end
        // A crossing in the cycle of a clearing write must survive it
        @(posedge clock_i);
        lvl <= 1'b1;
        repeat (2) @(posedge clock_i);
        wr_reg(2'h3, 8'h01);
        flag = 1'b1;
        #1 pins();
        rd_reg(2'h3, {3'h0, out, 3'h0, flag});
        // Standby without keep-running gates the whole output path
        @(posedge clock_i);
        standby_i <= 1'b1;
        repeat (8) @(posedge clock_i);
        #1 check_bit(cdo, 1'b0);
        check_bit(ev, 1'b0);
        pins();
        keep = 1'b1;
        wr_reg(2'h0, {1'b1, pd, 2'h0, inv, 3'h1});
        repeat (8) @(posedge clock_i);
        wr_reg(2'h3, 8'h01);
        flag = 1'b0;
        set_lvl(1'b0);
        set_lvl(1'b1);
        // Reset in mid-run must bring back every reset value
        @(posedge clock_i);
        standby_i <= 1'b0;
        rst_n_i <= 1'b0;
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        en = 1'b0;
        keep = 1'b0;
        flag = 1'b0;
        rd_reg(2'h0, 8'h00);
        rd_reg(2'h1, 8'h01);
        rd_reg(2'h2, 8'h00);
        rd_reg(2'h3, 8'h00);
        pins();
        wrap_up();
    end
endmodule : tb_zero_cross_edge_detector

`default_nettype wire

//--- hdl/zc_sync.sv
/*
 * Multi-stage synchroniser for one asynchronous level.
 * Assumes the input may change at any time relative to clock_i.
 */
`timescale 1ns/1ps
`default_nettype none

module zc_sync
#(
    parameter int STAGES = 3
)
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic async_i,
    output logic sync_o
);

    logic [STAGES-1:0] chain_q;

    // Only the last stage leaves the module; earlier stages may be metastable
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            chain_q <= '0;
        else
            chain_q <= {chain_q[STAGES-2:0], async_i};
    end

    assign sync_o = chain_q[STAGES-1];

endmodule : zc_sync

`default_nettype wire

//--- hdl/zero_cross_edge_detector.sv
/*
 * Digital side of the zero-cross detector: control, polarity, event line,
 * pin drive, state synchroniser, edge flag and interrupt.
 * Assumes the analog comparator result arrives asynchronously on
 * comp_raw_i and that the pad is configured for analog use by software.
 */
// Summary of operation
// R1: Software sets sense pin analog, no pulls.
// R2: Pin drive enable routes output to pin.
// R3: Enable bit turns detector on.
// R4: Output may be invalid during start-up.
// R5: State reads 1 above threshold, 0 below.
// R6: Invert reverses output and state polarity.
// R7: Edges judged on polarity-adjusted output.
// R8: One asynchronous level event output.
// R9: No event inputs accepted.
// R10: Configured edge sets crossing flag.
// R11: Edge select field gates interrupts.
// R12: Interrupt needs source enabled and flag set.
// R13: Interrupt holds until flag cleared.
// R14: Edge select codes none/rise/fall/both 0-3.
// R15: Write one clears flag; zero ignored.
// R16: State lags output by three cycles.
// R17: Standby bit keeps outputs running.
// R18: Flag edges from consecutive synced samples.
// R19: Disabled means stable inactive, no flags.
`timescale 1ns/1ps
`default_nettype none

module zero_cross_edge_detector
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic comp_raw_i,
    input wire logic standby_i,
    input wire logic [1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic cross_detect_output_o,
    output logic pin_out_o,
    output logic pin_oe_n_o,
    output logic event_level_o,
    output logic irq_o
);

    zc_pkg::reg_req_s req;
    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i,
                   wr: reg_wr_i, rd: reg_rd_i};

    logic enable_q;
    logic invert_q;
    logic pin_drive_enable_q;
    logic keep_running_in_standby_q;
    zc_pkg::irq_edge_e irq_edge_select_q;
    logic irq_mask_q;
    logic crossing_flag_q;
    logic state_prev_q;
    logic [7:0] rdata_q;

    wire wr_ctrl = req.wr && (req.addr == zc_pkg::OFF_PRIMARY_CONTROL);
    wire wr_irqc = req.wr && (req.addr == zc_pkg::OFF_IRQ_CONTROL);
    wire wr_mask = req.wr && (req.addr == zc_pkg::OFF_IRQ_MASK);
    wire wr_stat = req.wr && (req.addr == zc_pkg::OFF_STATUS);

    // Unit is live when enabled, unless standby stops it and no keep-running
    wire unit_active = enable_q &&
        (!standby_i || keep_running_in_standby_q); // [R3] [R17]

    // Asynchronous path: comparator through polarity to event and pin
    wire adjusted_raw = unit_active & (comp_raw_i ^ invert_q); // [R6] [R19]
    assign cross_detect_output_o = adjusted_raw;
    assign event_level_o = adjusted_raw; // [R8] [R9]
    assign pin_out_o = adjusted_raw & pin_drive_enable_q; // [R2]
    assign pin_oe_n_o = ~(pin_drive_enable_q & unit_active); // [R2]

    // Start-up glitches are not masked: software waits out start-up [R4]
    wire state_sync;
    zc_sync #(.STAGES(zc_pkg::SYNC_STAGES)) u_sync
    (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .async_i(adjusted_raw),
        .sync_o(state_sync)
    ); // [R5] [R16]

    wire rise_seen = state_sync & ~state_prev_q; // [R18]
    wire fall_seen = ~state_sync & state_prev_q; // [R18]
    wire edge_hit =
        ((irq_edge_select_q == zc_pkg::EDGE_RISING) && rise_seen) ||
        ((irq_edge_select_q == zc_pkg::EDGE_FALLING) && fall_seen) ||
        ((irq_edge_select_q == zc_pkg::EDGE_BOTH) &&
         (rise_seen || fall_seen)); // [R7] [R10] [R14]
    wire flag_set = edge_hit && unit_active; // [R19]
    wire flag_clr = wr_stat && req.wdata[zc_pkg::BIT_FLAG]; // [R15]

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            enable_q <= zc_pkg::RST_PRIMARY_CONTROL[zc_pkg::BIT_ENABLE];
            invert_q <= zc_pkg::RST_PRIMARY_CONTROL[zc_pkg::BIT_INVERT];
            pin_drive_enable_q <=
                zc_pkg::RST_PRIMARY_CONTROL[zc_pkg::BIT_PIN_DRIVE];
            keep_running_in_standby_q <=
                zc_pkg::RST_PRIMARY_CONTROL[zc_pkg::BIT_STANDBY];
        end
        else if (wr_ctrl)
        begin
            enable_q <= req.wdata[zc_pkg::BIT_ENABLE]; // [R3]
            invert_q <= req.wdata[zc_pkg::BIT_INVERT]; // [R6]
            pin_drive_enable_q <= req.wdata[zc_pkg::BIT_PIN_DRIVE]; // [R2]
            keep_running_in_standby_q <= req.wdata[zc_pkg::BIT_STANDBY];
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            irq_edge_select_q <= zc_pkg::irq_edge_e'(zc_pkg::RST_IRQ_EDGE);
            irq_mask_q <= zc_pkg::RST_IRQ_MASK;
        end
        else
        begin
            if (wr_irqc)
                irq_edge_select_q <= zc_pkg::irq_edge_e'(req.wdata[1:0]);
            if (wr_mask)
                irq_mask_q <= req.wdata[0];
        end
    end

    // Set beats a same-cycle clear so no crossing is lost
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            crossing_flag_q <= 1'b0;
            state_prev_q <= 1'b0;
        end
        else
        begin
            state_prev_q <= state_sync;
            if (flag_set)
                crossing_flag_q <= 1'b1; // [R10]
            else if (flag_clr)
                crossing_flag_q <= 1'b0; // [R15]
        end
    end

    // Level request; drops only when the flag is cleared, the source disabled or the mask cleared
    assign irq_o = crossing_flag_q && irq_mask_q &&
        (irq_edge_select_q != zc_pkg::EDGE_NONE); // [R11] [R12] [R13]

    wire [7:0] rd_ctrl = {keep_running_in_standby_q, pin_drive_enable_q,
                          2'h0, invert_q, 2'h0, enable_q};
    wire [7:0] rd_irqc = {6'h00, irq_edge_select_q};
    wire [7:0] rd_mask = {7'h00, irq_mask_q};
    wire [7:0] rd_stat = {3'h0, state_sync, 3'h0, crossing_flag_q}; // [R5]
    wire [7:0] rd_mux =
        (req.addr == zc_pkg::OFF_PRIMARY_CONTROL) ? rd_ctrl :
        (req.addr == zc_pkg::OFF_IRQ_CONTROL) ? rd_irqc :
        (req.addr == zc_pkg::OFF_IRQ_MASK) ? rd_mask : rd_stat;

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            rdata_q <= 8'h00;
        else if (req.rd)
            rdata_q <= rd_mux;
        else
            rdata_q <= 8'h00;
    end

    assign reg_rdata_o = rdata_q;

    AST_EDGE_SETS_FLAG: assert property (@(posedge clock_i) // [R10]
        disable iff (!rst_n_i)
        flag_set |=> crossing_flag_q)
        else $error("Crossing edge did not set the flag");

    AST_CLEAR_ONE: assert property (@(posedge clock_i) // [R15]
        disable iff (!rst_n_i)
        flag_clr && !flag_set |=> !crossing_flag_q)
        else $error("Write one did not clear the flag");

    AST_CLEAR_ZERO: assert property (@(posedge clock_i) // [R15]
        disable iff (!rst_n_i)
        crossing_flag_q && !flag_clr |=> crossing_flag_q)
        else $error("Flag dropped without a clearing write");

    AST_IRQ_NEEDS_FLAG: assert property (@(posedge clock_i) // [R12]
        disable iff (!rst_n_i)
        irq_o |-> crossing_flag_q && irq_edge_select_q != zc_pkg::EDGE_NONE)
        else $error("Interrupt without flag or enabled source");

    AST_IRQ_HOLDS: assert property (@(posedge clock_i) // [R13]
        disable iff (!rst_n_i)
        irq_o && !flag_clr && !wr_irqc && !wr_mask |=> irq_o)
        else $error("Interrupt deasserted on its own");

    AST_STATE_LAG: assert property (@(posedge clock_i) // [R16]
        disable iff (!rst_n_i)
        ##3 state_sync == $past(adjusted_raw, 3))
        else $error("State bit lag is not three cycles");

    AST_RISE_ONLY: assert property (@(posedge clock_i) // [R7]
        disable iff (!rst_n_i)
        irq_edge_select_q == zc_pkg::EDGE_RISING && fall_seen |-> !flag_set)
        else $error("Falling edge flagged in rising mode");

    AST_DISABLED_QUIET: assert property (@(posedge clock_i) // [R19]
        disable iff (!rst_n_i)
        !enable_q |-> !event_level_o && !flag_set && !pin_out_o)
        else $error("Disabled unit produced activity");

    AST_NO_PIN: assert property (@(posedge clock_i) // [R2]
        disable iff (!rst_n_i)
        !pin_drive_enable_q |-> pin_oe_n_o && !pin_out_o)
        else $error("Pin driven without drive enable");

    AST_FALL_ONLY: assert property (@(posedge clock_i) // [R7]
        disable iff (!rst_n_i)
        irq_edge_select_q == zc_pkg::EDGE_FALLING && rise_seen |-> !flag_set)
        else $error("Rising edge flagged in falling mode");

    AST_NONE_NO_FLAG: assert property (@(posedge clock_i) // [R14]
        disable iff (!rst_n_i)
        irq_edge_select_q == zc_pkg::EDGE_NONE |-> !flag_set)
        else $error("Edge flagged with no edge selected");

    AST_BOTH_FLAGS: assert property (@(posedge clock_i) // [R10]
        disable iff (!rst_n_i)
        irq_edge_select_q == zc_pkg::EDGE_BOTH && unit_active &&
        (rise_seen || fall_seen) |=> crossing_flag_q)
        else $error("Edge missed in both-edges mode");

    AST_RISE_ONCE: assert property (@(posedge clock_i) // [R18]
        disable iff (!rst_n_i)
        rise_seen |=> !rise_seen)
        else $error("One rising transition seen twice");

    AST_FALL_ONCE: assert property (@(posedge clock_i) // [R18]
        disable iff (!rst_n_i)
        fall_seen |=> !fall_seen)
        else $error("One falling transition seen twice");

    AST_STATE_OFF: assert property (@(posedge clock_i) // [R19]
        disable iff (!rst_n_i)
        (!enable_q) [*4] |-> !state_sync)
        else $error("State bit active while disabled");

    AST_READ_STATUS: assert property (@(posedge clock_i) // [R5]
        disable iff (!rst_n_i)
        req.rd && req.addr == zc_pkg::OFF_STATUS |=>
        reg_rdata_o[zc_pkg::BIT_STATE] == $past(state_sync) &&
        reg_rdata_o[zc_pkg::BIT_FLAG] == $past(crossing_flag_q))
        else $error("Status read does not show state and flag");

    AST_READ_CTRL: assert property (@(posedge clock_i) // [R3]
        disable iff (!rst_n_i)
        req.rd && req.addr == zc_pkg::OFF_PRIMARY_CONTROL |=>
        reg_rdata_o[zc_pkg::BIT_ENABLE] == $past(enable_q) &&
        reg_rdata_o[zc_pkg::BIT_INVERT] == $past(invert_q))
        else $error("Control read does not show enable and invert");

    AST_ENABLE_ON: assert property (@(posedge clock_i) // [R3]
        disable iff (!rst_n_i)
        wr_ctrl && req.wdata[zc_pkg::BIT_ENABLE] |=> enable_q)
        else $error("Writing one did not enable the unit");

    AST_ENABLE_OFF: assert property (@(posedge clock_i) // [R3]
        disable iff (!rst_n_i)
        wr_ctrl && !req.wdata[zc_pkg::BIT_ENABLE] |=> !enable_q)
        else $error("Writing zero did not leave the unit off");

    AST_INVERT_ON: assert property (@(posedge clock_i) // [R6]
        disable iff (!rst_n_i)
        wr_ctrl && req.wdata[zc_pkg::BIT_INVERT] |=> invert_q)
        else $error("Writing one did not select inversion");

    AST_PIN_DRIVE: assert property (@(posedge clock_i) // [R2]
        disable iff (!rst_n_i)
        pin_drive_enable_q && unit_active |->
        !pin_oe_n_o && pin_out_o == cross_detect_output_o)
        else $error("Output not routed to the pin");

    AST_STANDBY_KEEP: assert property (@(posedge clock_i) // [R17]
        disable iff (!rst_n_i)
        enable_q && keep_running_in_standby_q |->
        cross_detect_output_o == (comp_raw_i ^ invert_q))
        else $error("Keep-running unit stopped in standby");

    AST_STANDBY_STOP: assert property (@(posedge clock_i) // [R17]
        disable iff (!rst_n_i)
        standby_i && !keep_running_in_standby_q |->
        !cross_detect_output_o && !flag_set)
        else $error("Unit active in standby without keep-running");

    AST_IRQ_ON: assert property (@(posedge clock_i) // [R12]
        disable iff (!rst_n_i)
        crossing_flag_q && irq_mask_q &&
        irq_edge_select_q != zc_pkg::EDGE_NONE |-> irq_o)
        else $error("Interrupt missing with flag set and source on");

    AST_MODE_RISING: assert property (@(posedge clock_i) // [R14]
        disable iff (!rst_n_i)
        wr_irqc && req.wdata[1:0] == 2'h1 |=>
        irq_edge_select_q == zc_pkg::EDGE_RISING)
        else $error("Code one did not select rising edges");

    AST_FLAG_NEEDS_EDGE: assert property (@(posedge clock_i) // [R10]
        disable iff (!rst_n_i)
        !crossing_flag_q && !flag_set |=> !crossing_flag_q)
        else $error("Flag set without a crossing");

    AST_SET_WINS: assert property (@(posedge clock_i) // [R10]
        disable iff (!rst_n_i)
        flag_set && flag_clr |=> crossing_flag_q)
        else $error("Clearing write hid a same-cycle crossing");

endmodule : zero_cross_edge_detector

`default_nettype wire
